// ### rtl/down_timer_pkg.sv
/*
  constants for the down-counting timer with pwm output: register
  byte offsets, field positions, reset values, fixed count values.
  assumes a 32-bit ahb-lite register bus, one word per register.
*/
package down_timer_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_ONE_ADDR   = 8'h00; // counter_control_one
  localparam logic [7:0] CTRL_TWO_ADDR   = 8'h04; // counter_control_two
  localparam logic [7:0] COUNT_ADDR      = 8'h08; // counter_value_register
  localparam logic [7:0] DUTY_ADDR       = 8'h0C; // pwm_duty_register
  localparam logic [7:0] PSC_VALUE_ADDR  = 8'h10; // prescaler_current_value
  localparam logic [7:0] FLAG_ADDR       = 8'h14; // interrupt_flag_register
  localparam logic [7:0] IRQ_EN_ADDR     = 8'h18; // irq enables

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int RUN_BIT      = 0; // counter_run_enable
  localparam int RELOAD_BIT   = 1; // reload_on_underflow_select
  localparam int ONE_SHOT_BIT = 2; // one_shot_select
  localparam int PWM_AL_BIT   = 6; // pwm_active_low_select
  localparam int PWM_EN_BIT   = 7; // pwm_output_enable
  localparam int RATIO_LSB    = 0; // prescaler_ratio_select [2:0]
  localparam int RATIO_MSB    = 2;
  localparam int PSC_EN_N_BIT = 3; // prescaler_enable_n
  localparam int EDGE_BIT     = 4; // clock_edge_select
  localparam int SRC_BIT      = 5; // clock_source_select
  localparam int UFL_BIT      = 3; // underflow_flag / its enable
  localparam int GIE_BIT      = 7; // global_irq_enable

  // ----------------------------------------------------------------
  // reset values and fixed counts
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_ONE_RST = 8'h00;
  localparam logic [7:0] CTRL_TWO_RST = 8'h08; // prescaler bypassed
  localparam logic [7:0] BYTE_ZERO    = 8'h00;
  localparam logic [7:0] BYTE_FULL    = 8'hFF; // wrap restart value
  localparam logic [7:0] BYTE_ONE     = 8'h01;
  localparam logic [15:0] DIV_BASE    = 16'h0002; // smallest ratio 1:2
  localparam logic [15:0] DIV_ONE     = 16'h0001;
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic       HRESP_OKAY    = 1'b0;

  // counter sequencing
  typedef enum logic {counting, expired} cnt_state_t;

endpackage : down_timer_pkg

// ### rtl/down_timer_with_pwm.sv
/*
  8-bit down-counting timer with prescaler, external clock edge
  select, one-shot / continuous modes, sticky underflow flag and a
  pwm pin driver, behind an ahb-lite slave with zero wait states.
  assumes instr_tick is a one-cycle pulse on core_clk per
  instruction clock, and that the external clock pin is async.
*/
`timescale 1ns/10ps
`default_nettype none

// Function
// - 8-bit counter decrements per selected tick
// - count write loads reload and counter
// - count read returns live count
// - counter runs only while run bit set
// - source select: 1 pin, 0 instruction
// - edge select: 1 falling, 0 rising
// - prescaler enable low, ratio 1:2..1:256
// - prescaler count readable in own register
// - one-shot counts down once, then stops
// - continuous, reload bit 1: restore reload
// - continuous, reload bit 0: restart 0xFF
// - underflow sets flag bit 3
// - irq needs flag, enable and global
// - flag stays until software writes 0
// - pwm enable drives pin as output
// - polarity bit 1 means active low
// - duty zero keeps pwm inactive
// - active time equals duty in ticks
// - pin clock used when source bit 1
module down_timer_with_pwm
  import down_timer_pkg::*;
(
  // clock, reset, enable
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire logic        clk_en,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  // clock sources
  input  wire logic        instr_tick,
  input  wire logic        external_clock_pin,
  // pins and request
  output logic             pwm_pin_out,
  output logic             pwm_pin_oe,
  output logic             irq_out
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0]  ctrl_one_ff;   // run, reload, one-shot, pwm
  logic [7:0]  ctrl_two_ff;   // ratio, prescaler, edge, source
  logic [7:0]  count_ff;      // live down count
  logic [7:0]  reload_ff;     // stored reload value
  logic [7:0]  duty_ff;       // pwm duty
  logic [7:0]  psc_ff;        // prescaler count
  logic        flag_ff;       // sticky underflow flag
  logic        ufl_ie_ff;     // underflow_irq_enable
  logic        gie_ff;        // global_irq_enable
  cnt_state_t  state_ff;      // counting or one-shot expired
  logic        wr_pend_ff;    // write data phase pending
  logic [7:0]  wr_addr_ff;    // its address
  logic [2:0]  ext_sync_ff;   // pin synchroniser chain
  logic        ext_lvl_ff;    // agreed pin level
  logic        hreadyout_ff;
  logic [31:0] hrdata_ff;
  logic        pwm_out_ff;
  logic        pwm_oe_ff;
  logic        irq_ff;

  // ----------------------------------------------------------------
  // combinational terms
  // ----------------------------------------------------------------
  logic        addr_phase;    // request taken this edge
  logic        wr_do;         // write data applied this edge
  logic        cnt_wr;        // software writes the count
  logic        flag_clr;      // software writes 0 to the flag
  logic        ext_agree;     // second and third flops agree
  logic        ext_rise;
  logic        ext_fall;
  logic        src_tick;      // selected source event
  logic        psc_tick;      // prescaler division output
  logic        cnt_tick;      // counter decrement event
  logic        underflow;     // tick while count is zero
  logic        pwm_act;       // pwm active before polarity
  logic [7:0]  psc_mask;
  logic [7:0]  rd_byte;

  // ratio n divides by 2^(n+1): terminal count mask
  function automatic logic [7:0] ratio_mask(input logic [2:0] r);
    logic [15:0] d;
    d = (DIV_BASE << r) - DIV_ONE;
    return d[7:0];
  endfunction : ratio_mask

  assign addr_phase = hsel && htrans[1] && hready;
  assign wr_do      = wr_pend_ff;
  assign cnt_wr     = wr_do && (wr_addr_ff == COUNT_ADDR);
  assign flag_clr   = wr_do && (wr_addr_ff == FLAG_ADDR)
                      && !hwdata[UFL_BIT];

  // ----------------------------------------------------------------
  // external pin synchroniser
  // ----------------------------------------------------------------
  // three flops; a level counts only when the last two agree,
  // so a single-cycle glitch never reaches the counter
  always_ff @(posedge core_clk)
  begin
    if (reset)
      ext_sync_ff <= 3'b000;
    else if (clk_en)
      ext_sync_ff <= {ext_sync_ff[1:0], external_clock_pin};
  end

  assign ext_agree = ext_sync_ff[1] == ext_sync_ff[2];

  // agreed level, edges come from it
  always_ff @(posedge core_clk)
  begin
    if (reset)
      ext_lvl_ff <= 1'b0;
    else if (clk_en && ext_agree)
      ext_lvl_ff <= ext_sync_ff[2];
  end

  assign ext_rise = ext_agree && ext_sync_ff[2] && !ext_lvl_ff;
  assign ext_fall = ext_agree && !ext_sync_ff[2] && ext_lvl_ff;

  // ----------------------------------------------------------------
  // source select and prescaler
  // ----------------------------------------------------------------
  always_comb
  begin
    if (ctrl_two_ff[SRC_BIT])
      src_tick = ctrl_two_ff[EDGE_BIT] ? ext_fall : ext_rise;
    else
      src_tick = instr_tick;
  end

  assign psc_mask = ratio_mask(ctrl_two_ff[RATIO_MSB:RATIO_LSB]);
  assign psc_tick = src_tick && ((psc_ff & psc_mask) == psc_mask);
  // prescaler is skipped when its active-low enable is 1
  assign cnt_tick = clk_en && ctrl_one_ff[RUN_BIT]
                    && state_ff == counting
                    && (ctrl_two_ff[PSC_EN_N_BIT] ? src_tick
                                                  : psc_tick);
  assign underflow = cnt_tick && (count_ff == BYTE_ZERO);

  // prescaler counts source events while the run bit is set; it wraps at 256
  always_ff @(posedge core_clk)
  begin
    if (reset)
      psc_ff <= BYTE_ZERO;
    else if (clk_en && (wr_do && wr_addr_ff == CTRL_TWO_ADDR))
      psc_ff <= BYTE_ZERO;             // restart on new ratio
    else if (clk_en && src_tick && ctrl_one_ff[RUN_BIT])
      psc_ff <= psc_ff + BYTE_ONE;
  end

  // ----------------------------------------------------------------
  // down counter and reload
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (reset)
      count_ff <= BYTE_ZERO;
    else if (clk_en)
    begin
      if (cnt_wr)
        count_ff <= hwdata[7:0];
      else if (underflow)
      begin
        if (ctrl_one_ff[ONE_SHOT_BIT])
          count_ff <= BYTE_ZERO;
        else if (ctrl_one_ff[RELOAD_BIT])
          count_ff <= reload_ff;
        else
          count_ff <= BYTE_FULL;
      end
      else if (cnt_tick)
        count_ff <= count_ff - BYTE_ONE;
    end
  end

  // reload value changes only by a count write
  always_ff @(posedge core_clk)
  begin
    if (reset)
      reload_ff <= BYTE_ZERO;
    else if (clk_en && cnt_wr)
      reload_ff <= hwdata[7:0];
  end

  // one-shot stops after its underflow until a count write or the one-shot bit is cleared
  always_ff @(posedge core_clk)
  begin
    if (reset)
      state_ff <= counting;
    else if (clk_en)
    begin
      unique case (state_ff)
        counting:
        begin
          if (underflow && ctrl_one_ff[ONE_SHOT_BIT] && !cnt_wr)
            state_ff <= expired;
        end
        expired:
        begin
          if (cnt_wr || !ctrl_one_ff[ONE_SHOT_BIT])
            state_ff <= counting;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // underflow flag and interrupt request
  // ----------------------------------------------------------------
  // set wins over a clear written in the same cycle
  always_ff @(posedge core_clk)
  begin
    if (reset)
      flag_ff <= 1'b0;
    else if (clk_en)
    begin
      if (underflow)
        flag_ff <= 1'b1;
      else if (flag_clr)
        flag_ff <= 1'b0;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
      irq_ff <= 1'b0;
    else if (clk_en)
      irq_ff <= flag_ff && ufl_ie_ff && gie_ff;
  end

  // ----------------------------------------------------------------
  // pwm
  // ----------------------------------------------------------------
  // count zero is excluded so active time is exactly duty ticks
  assign pwm_act = (duty_ff != BYTE_ZERO)
                   && (count_ff != BYTE_ZERO)
                   && (count_ff <= duty_ff);

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      pwm_out_ff <= 1'b0;
      pwm_oe_ff  <= 1'b0;
    end
    else if (clk_en)
    begin
      pwm_out_ff <= pwm_act ^ ctrl_one_ff[PWM_AL_BIT];
      pwm_oe_ff  <= ctrl_one_ff[PWM_EN_BIT];
    end
  end

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      ctrl_one_ff <= CTRL_ONE_RST;
      ctrl_two_ff <= CTRL_TWO_RST;
      duty_ff     <= BYTE_ZERO;
      ufl_ie_ff   <= 1'b0;
      gie_ff      <= 1'b0;
    end
    else if (clk_en && wr_do)
    begin
      unique case (wr_addr_ff)
        CTRL_ONE_ADDR: ctrl_one_ff <= hwdata[7:0];
        CTRL_TWO_ADDR: ctrl_two_ff <= hwdata[7:0];
        DUTY_ADDR:     duty_ff     <= hwdata[7:0];
        IRQ_EN_ADDR:
        begin
          ufl_ie_ff <= hwdata[UFL_BIT];
          gie_ff    <= hwdata[GIE_BIT];
        end
        default:       ;          // unmapped writes are dropped
      endcase
    end
  end

  // ----------------------------------------------------------------
  // ahb-lite slave
  // ----------------------------------------------------------------
  // read mux from the address phase; unused control bits read back as written, other reserved bits read zero
  always_comb
  begin
    rd_byte = BYTE_ZERO;
    unique case (haddr[7:0])
      CTRL_ONE_ADDR:  rd_byte = ctrl_one_ff;
      CTRL_TWO_ADDR:  rd_byte = ctrl_two_ff;
      COUNT_ADDR:     rd_byte = count_ff;
      DUTY_ADDR:      rd_byte = duty_ff;
      PSC_VALUE_ADDR: rd_byte = psc_ff;
      FLAG_ADDR:      rd_byte[UFL_BIT] = flag_ff;
      IRQ_EN_ADDR:
      begin
        rd_byte[UFL_BIT] = ufl_ie_ff;
        rd_byte[GIE_BIT] = gie_ff;
      end
      default:        rd_byte = BYTE_ZERO;
    endcase
  end

  // zero wait states: data phase always completes at once
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      wr_pend_ff   <= 1'b0;
      wr_addr_ff   <= BYTE_ZERO;
      hrdata_ff    <= 32'h0000_0000;
      hreadyout_ff <= 1'b1;
    end
    else if (clk_en)
    begin
      wr_pend_ff   <= addr_phase && hwrite;
      hreadyout_ff <= 1'b1;
      if (addr_phase)
        wr_addr_ff <= haddr[7:0];
      if (addr_phase && !hwrite)
        hrdata_ff <= {24'h00_0000, rd_byte};
    end
  end

  assign hreadyout   = hreadyout_ff;
  assign hrdata      = hrdata_ff;
  assign hresp       = HRESP_OKAY;
  assign pwm_pin_out = pwm_out_ff;
  assign pwm_pin_oe  = pwm_oe_ff;
  assign irq_out     = irq_ff;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);

  count_dec_a: assert property (
    (cnt_tick && !underflow && !cnt_wr)
      |=> count_ff == $past(count_ff) - BYTE_ONE)
    else $error("counter did not decrement by one");

  count_load_a: assert property (
    (clk_en && cnt_wr)
      |=> count_ff == reload_ff && count_ff == $past(hwdata[7:0]))
    else $error("count write did not load both registers");

  count_hold_a: assert property (
    (clk_en && !ctrl_one_ff[RUN_BIT] && !cnt_wr) |=> $stable(count_ff))
    else $error("stopped counter changed");

  one_shot_a: assert property (
    (underflow && ctrl_one_ff[ONE_SHOT_BIT] && !cnt_wr)
      |=> state_ff == expired && count_ff == BYTE_ZERO)
    else $error("one-shot did not stop at zero");

  reload_restore_a: assert property (
    (underflow && !ctrl_one_ff[ONE_SHOT_BIT]
     && ctrl_one_ff[RELOAD_BIT] && !cnt_wr)
      |=> count_ff == $past(reload_ff))
    else $error("reload value not restored");

  wrap_full_a: assert property (
    (underflow && !ctrl_one_ff[ONE_SHOT_BIT]
     && !ctrl_one_ff[RELOAD_BIT] && !cnt_wr)
      |=> count_ff == BYTE_FULL)
    else $error("continuous wrap did not restart at ff");

  flag_set_a: assert property (underflow |=> flag_ff)
    else $error("underflow did not set flag");

  flag_hold_a: assert property (
    (flag_ff && !(clk_en && flag_clr)) |=> flag_ff)
    else $error("flag cleared without a zero write");

  irq_gate_a: assert property (
    (clk_en && !(flag_ff && ufl_ie_ff && gie_ff)) |=> !irq_out)
    else $error("irq raised without all three enables");

  pwm_idle_a: assert property (
    (clk_en && duty_ff == BYTE_ZERO)
      |=> pwm_pin_out == $past(ctrl_one_ff[PWM_AL_BIT]))
    else $error("pwm active with zero duty");

  pwm_dir_a: assert property (
    clk_en |=> pwm_pin_oe == $past(ctrl_one_ff[PWM_EN_BIT]))
    else $error("pwm pin direction not following enable");

endmodule : down_timer_with_pwm

`default_nettype wire

// ### testbench/down_timer_with_pwm_tb_top.sv
/*
  self-checking bench for the down timer with pwm: ahb-lite reads and
  writes, counting, underflow modes, flag and irq, pin clock, prescaler
  and pwm. assumes zero-wait slave and one clock domain.
*/
`timescale 1ns/10ps
`default_nettype none
module down_timer_with_pwm_tb_top;
  import down_timer_pkg::*;

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  localparam int         LIMIT   = 40000; // run should need ~5k cycles
  localparam logic [7:0] RUN_M   = 8'h01 << RUN_BIT;
  localparam logic [7:0] RLD_M   = 8'h01 << RELOAD_BIT;
  localparam logic [7:0] OS_M    = 8'h01 << ONE_SHOT_BIT;
  localparam logic [7:0] PWM_M   = 8'h01 << PWM_EN_BIT;
  logic        core_clk, reset, clk_en, hsel, hwrite, instr_tick;
  logic        external_clock_pin, hreadyout, hresp;
  logic        pwm_pin_out, pwm_pin_oe, irq_out;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [7:0]  v, d, c, e1, e2, ctl;
  logic        al;
  int          seed, n_fail, checks_done, cyc, act, dv;

  down_timer_with_pwm down_timer_with_pwm_i (
    .core_clk(core_clk), .reset(reset), .clk_en(clk_en),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .instr_tick(instr_tick), .external_clock_pin(external_clock_pin),
    .pwm_pin_out(pwm_pin_out), .pwm_pin_oe(pwm_pin_oe), .irq_out(irq_out));

  initial core_clk = 1'b0;
  always #5 core_clk = ~core_clk;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e)
    begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  // waits for hready high at a rising edge; only the bench timeout
  // ends a slave that never answers
  task automatic wait_ready;
    @(posedge core_clk);
    while (hreadyout !== 1'b1)
      @(posedge core_clk);
  endtask : wait_ready

  // one single word transfer: address phase, then data phase
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge core_clk);
    hsel   <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr  <= {24'h00_0000, a};
    hwrite <= wr;
    wait_ready();
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [7:0] dat);
    logic [31:0] dummy;
    bus(1'b1, a, {24'h00_0000, dat}, dummy);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0000_0000, r);
    chk(r, {24'h00_0000, e});
    // the slave never signals an error
    chk({31'h0, hresp}, {31'h0, HRESP_OKAY});
  endtask : rd_chk

  // one instruction clock pulse per two core cycles
  task automatic ticks(input int n);
    repeat (n)
    begin
      @(posedge core_clk);
      instr_tick <= 1'b1;
      @(posedge core_clk);
      instr_tick <= 1'b0;
    end
  endtask : ticks

  // pin level held long enough for the synchroniser to agree
  task automatic pin_to(input logic lv);
    @(posedge core_clk);
    external_clock_pin <= lv;
    repeat (8) @(posedge core_clk);
  endtask : pin_to

  function automatic logic pwm_exp(logic [7:0] cn, logic [7:0] du,
                                   logic lo);
    return ((cn != 8'h00) && (cn <= du) && (du != 8'h00)) ^ lo;
  endfunction : pwm_exp

  task automatic wrap_up;
    $display("checks %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up

  // hang guard: counts as a mismatch
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == LIMIT)
    begin
      n_fail++;
      wrap_up();
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    seed = 65;
    {n_fail, checks_done, cyc} = '0;
    {reset, clk_en, hsel, hwrite} = 4'b1100;
    {haddr, hwdata, htrans} = '0;
    hsize = 3'b010;
    {instr_tick, external_clock_pin} = 2'b00;
    repeat (4) @(posedge core_clk);
    reset <= 1'b0;
    // reset values, plus one unmapped word
    for (int i = 0; i < 8; i++)
      rd_chk(8'(i * 4), (i == 1) ? CTRL_TWO_RST : BYTE_ZERO);
    chk({30'h0, pwm_pin_oe, irq_out}, 32'h0000_0000);
    wr(IRQ_EN_ADDR, 8'h08); // underflow irq enable on, global enable off
    // hold while stopped, then count the exact number of ticks
    v = 8'h20 | 8'($random(seed));
    dv = 1 + ($random(seed) & 15);
    wr(COUNT_ADDR, v);
    ticks(3);
    rd_chk(COUNT_ADDR, v);
    wr(CTRL_ONE_ADDR, RUN_M);
    ticks(dv);
    // clock enable low freezes the counter, so these ticks are lost
    clk_en <= 1'b0;
    ticks(4);
    clk_en <= 1'b1;
    rd_chk(COUNT_ADDR, v - 8'(dv));
    // underflow in reload, wrap and one-shot modes
    for (int m = 0; m < 3; m++)
    begin
      v = 8'(2 + ($random(seed) & 15));
      ctl = RUN_M | ((m == 0) ? RLD_M : (m == 2) ? OS_M : 8'h00);
      e1 = (m == 0) ? v : (m == 1) ? BYTE_FULL : BYTE_ZERO;
      e2 = (m == 2) ? BYTE_ZERO : e1 - 8'h02;
      wr(CTRL_ONE_ADDR, 8'h00);
      wr(FLAG_ADDR, 8'h00);
      wr(COUNT_ADDR, v);
      wr(CTRL_ONE_ADDR, ctl);
      ticks(int'(v));
      rd_chk(FLAG_ADDR, 8'h00);
      ticks(1);
      rd_chk(COUNT_ADDR, e1);
      rd_chk(FLAG_ADDR, 8'h08);
      ticks(2);
      rd_chk(COUNT_ADDR, e2);
    end
    // flag is sticky; irq needs flag and both enables
    wr(FLAG_ADDR, 8'hFF);
    rd_chk(FLAG_ADDR, 8'h08);
    for (int k = 0; k < 4; k++)
    begin
      wr(IRQ_EN_ADDR, {k[1], 3'b000, k[0], 3'b000});
      repeat (3) @(posedge core_clk);
      chk({31'h0, irq_out}, {31'h0, k == 3});
    end
    wr(FLAG_ADDR, 8'h00);
    rd_chk(FLAG_ADDR, 8'h00);
    repeat (3) @(posedge core_clk);
    chk({31'h0, irq_out}, 32'h0000_0000);
    // external pin: three rises, two falls, instruction ticks ignored
    for (int e = 0; e < 2; e++)
    begin
      wr(CTRL_ONE_ADDR, 8'h00);
      pin_to(1'b0);
      wr(CTRL_TWO_ADDR, 8'h28 | 8'(e << EDGE_BIT));
      wr(COUNT_ADDR, 8'h40);
      wr(CTRL_ONE_ADDR, RUN_M);
      for (int j = 0; j < 5; j++)
        pin_to(j % 2 == 0);
      ticks(2);
      rd_chk(COUNT_ADDR, (e == 1) ? 8'h3E : 8'h3D);
    end
    // prescaler at every ratio
    for (int n = 0; n < 8; n++)
    begin
      wr(CTRL_ONE_ADDR, 8'h00);
      wr(CTRL_TWO_ADDR, 8'(n));
      wr(COUNT_ADDR, 8'h80);
      wr(CTRL_ONE_ADDR, RUN_M);
      ticks((2 << n) * 2 + 1);
      rd_chk(COUNT_ADDR, 8'h7E);
      // the prescaler has counted every source event, modulo 256
      rd_chk(PSC_VALUE_ADDR, 8'((4 << n) + 1));
      wr(CTRL_TWO_ADDR, 8'(n));
      rd_chk(PSC_VALUE_ADDR, 8'h00);
    end
    // pwm level against count, duty and polarity, stopped counter
    wr(CTRL_TWO_ADDR, CTRL_TWO_RST);
    for (int i = 0; i < 12; i++)
    begin
      c = (i == 1) ? 8'h00 : (i == 2) ? 8'hFF : 8'($random(seed));
      d = (i == 0) ? 8'h00 : (i == 2) ? 8'hFF : c & 8'($random(seed));
      al = i[0];
      wr(CTRL_ONE_ADDR, PWM_M | (8'(al) << PWM_AL_BIT));
      wr(COUNT_ADDR, c);
      wr(DUTY_ADDR, d);
      repeat (3) @(posedge core_clk);
      chk({31'h0, pwm_pin_out}, {31'h0, pwm_exp(c, d, al)});
      chk({31'h0, pwm_pin_oe}, 32'h0000_0001);
    end
    wr(CTRL_ONE_ADDR, 8'h00);
    repeat (3) @(posedge core_clk);
    chk({31'h0, pwm_pin_oe}, 32'h0000_0000);
    // active ticks over a whole frame equal the duty value
    for (int f = 0; f < 2; f++)
    begin
      v = f ? 8'hFF : 8'h10 | 8'($random(seed));
      d = f ? 8'hFF : v & 8'($random(seed));
      wr(CTRL_ONE_ADDR, 8'h00);
      wr(COUNT_ADDR, v);
      wr(DUTY_ADDR, d);
      wr(CTRL_ONE_ADDR, RUN_M | RLD_M | PWM_M);
      act = 0;
      repeat (int'(v) + 1)
      begin
        repeat (3) @(posedge core_clk);
        act += (pwm_pin_out === 1'b1);
        ticks(1);
      end
      chk(32'(act), {24'h00_0000, d});
    end
    wrap_up();
  end
endmodule : down_timer_with_pwm_tb_top
`default_nettype wire
